// *** hdl/pfsa_pkg.sv ***
// Constants, types and carriers of the program flash self-access controller
//------------------------------------------------------------------------------
// Summary of operation
// - Data 14 bits, address 15 bits, byte pairs
// - Address high byte holds MSB, reaches 32K
// - Start bits set-only, hardware clears at completion
// - Writes need write_enable; clear after power-up
// - Reset with por low during write sets write_error_flag
// - Unlock register reads back as zero
// - Unlock pattern must precede every write
// - Erase acts on whole 32-word rows
// - Hidden 14-bit latches filled via data pair
// - Fetch in second cycle, data next cycle
// - Data pair holds until next read/write
// - Code protect blocks only external programmer access
// - Write protect blocks self-write in region
// - Internal timer ends erase/program, clears start bit; lwlo latch load ends at once
//------------------------------------------------------------------------------
package pfsa_pkg;
    // Timing
    localparam int CLK_MHZ    = 20;
    localparam int T_WRITE_US = 2000;
    localparam int WRITE_CYC  = T_WRITE_US * CLK_MHZ;
    localparam int TMR_W      = 24;
    // Geometry
    localparam int WORD_W   = 14;
    localparam int ADDR_W   = 15;
    localparam int ROW_W    = 5;
    localparam int ROW_WORDS = 32;
    localparam logic [WORD_W-1:0] LATCH_RST = 14'h3fff;
    // Unlock pattern
    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
    // Control register bit positions
    localparam int CB_RD    = 0;
    localparam int CB_WR    = 1;
    localparam int CB_WRITE_ENABLE  = 2;
    localparam int CB_WRITE_ERROR_FLAG = 3;
    localparam int CB_FREE  = 4;
    localparam int CB_LWLO  = 5;
    localparam int CB_CONFIG_SPACE_SELECT  = 6;
    // Write protection regions
    localparam logic [1:0]        WP_NONE     = 2'b11;
    localparam logic [1:0]        WP_LOW      = 2'b10;
    localparam logic [1:0]        WP_HALF     = 2'b01;
    localparam logic [ADDR_W-1:0] WP_LOW_END  = 15'h01ff;
    localparam logic [ADDR_W-1:0] WP_HALF_END = 15'h0fff;

    typedef enum logic [2:0] {
        SEL_CTRL, SEL_UNLOCK, SEL_DATA_LO, SEL_DATA_HI, SEL_ADDR_LO, SEL_ADDR_HI
    } pfsa_sel_t;

    typedef struct packed {
        logic      wr;
        logic      rd;
        pfsa_sel_t sel;
        logic [7:0] wdata;
    } pfsa_sfr_t;

    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_LOAD, ST_BUSY} pfsa_state_t;

    typedef struct packed {
        pfsa_state_t                           state;
        logic                                  rd;
        logic                                  wr;
        logic                                  write_enable;
        logic                                  write_error_flag;
        logic                                  free;
        logic                                  lwlo;
        logic                                  config_space_select;
        logic [1:0]                            unlock;
        logic [ADDR_W-1:0]                     addr;
        logic [WORD_W-1:0]                     data;
        logic [ROW_WORDS-1:0][WORD_W-1:0]      latch;
        logic [TMR_W-1:0]                      timer;
        logic                                  erase_go;
        logic                                  prog_go;
        logic [7:0]                            rdata;
    } pfsa_regs_t;
endpackage

// *** hdl/pfsa_flash_ctrl.sv ***
// Program flash self-access controller: SFR side, write latches, timed writes
module pfsa_flash_ctrl #(
    parameter int WRITE_CYC = pfsa_pkg::WRITE_CYC
) (
    // Clock and reset
    input  wire logic                           clk_sys,
    input  wire logic                           rst,
    input  wire logic                           por,
    // Core SFR access
    input  wire pfsa_pkg::pfsa_sfr_t            sfr,
    output logic [7:0]                          sfr_rdata,
    // Configuration words
    input  wire logic                           code_protect,
    input  wire logic [1:0]                     write_protect_region,
    output logic                                ext_access_allow,
    // Flash array
    output logic [pfsa_pkg::ADDR_W-1:0]         fl_addr,
    output logic                                fl_cfg,
    output logic                                fl_rd,
    input  wire logic [pfsa_pkg::WORD_W-1:0]    fl_rdata,
    output logic                                fl_erase,
    output logic                                fl_prog,
    output logic                                fl_busy,
    output logic [pfsa_pkg::ROW_WORDS-1:0][pfsa_pkg::WORD_W-1:0] fl_row_data
);
    //--------------------------------------------------------------------------
    // State
    //--------------------------------------------------------------------------
    pfsa_pkg::pfsa_regs_t st;
    pfsa_pkg::pfsa_regs_t next_st;

    logic ctrl_wr;
    logic armed;
    logic wp_hit;
    logic wr_start;
    logic rd_start;
    logic [7:0] ctrl_byte;

    // Write protection decode over the current address
    always_comb begin
        unique case (write_protect_region)
            pfsa_pkg::WP_NONE: wp_hit = 1'b0;
            pfsa_pkg::WP_LOW:  wp_hit = st.addr <= pfsa_pkg::WP_LOW_END;
            pfsa_pkg::WP_HALF: wp_hit = st.addr <= pfsa_pkg::WP_HALF_END;
            default:           wp_hit = 1'b1;
        endcase
    end

    // Start qualification; a refused start never sets the start bit
    assign ctrl_wr  = sfr.wr && sfr.sel == pfsa_pkg::SEL_CTRL;
    assign armed    = st.unlock == 2'd2;
    assign wr_start = ctrl_wr && sfr.wdata[pfsa_pkg::CB_WR] && st.state == pfsa_pkg::ST_IDLE
                      && st.write_enable && armed && !wp_hit;
    assign rd_start = ctrl_wr && sfr.wdata[pfsa_pkg::CB_RD] && st.state == pfsa_pkg::ST_IDLE
                      && !wr_start;

    // Control register image; bit 7 reads zero
    always_comb begin
        ctrl_byte = 8'h00;
        ctrl_byte[pfsa_pkg::CB_RD]    = st.rd;
        ctrl_byte[pfsa_pkg::CB_WR]    = st.wr;
        ctrl_byte[pfsa_pkg::CB_WRITE_ENABLE]  = st.write_enable;
        ctrl_byte[pfsa_pkg::CB_WRITE_ERROR_FLAG] = st.write_error_flag;
        ctrl_byte[pfsa_pkg::CB_FREE]  = st.free;
        ctrl_byte[pfsa_pkg::CB_LWLO]  = st.lwlo;
        ctrl_byte[pfsa_pkg::CB_CONFIG_SPACE_SELECT]  = st.config_space_select;
    end

    //--------------------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------------------
    always_comb begin
        next_st          = st;
        next_st.erase_go = 1'b0;
        next_st.prog_go  = 1'b0;

        // Read-back, one cycle after the read strobe
        if (sfr.rd) begin
            unique case (sfr.sel)
                pfsa_pkg::SEL_CTRL:    next_st.rdata = ctrl_byte;
                pfsa_pkg::SEL_UNLOCK:  next_st.rdata = 8'h00;
                pfsa_pkg::SEL_DATA_LO: next_st.rdata = st.data[7:0];
                pfsa_pkg::SEL_DATA_HI: next_st.rdata = {2'b00, st.data[13:8]};
                pfsa_pkg::SEL_ADDR_LO: next_st.rdata = st.addr[7:0];
                pfsa_pkg::SEL_ADDR_HI: next_st.rdata = {1'b0, st.addr[14:8]};
                default:               next_st.rdata = 8'h00;
            endcase
        end

        // Unlock tracker: key1 then key2, consumed by any other write
        if (sfr.wr) begin
            if (sfr.sel == pfsa_pkg::SEL_UNLOCK && sfr.wdata == pfsa_pkg::UNLOCK_KEY1) begin
                next_st.unlock = 2'd1;
            end else if (sfr.sel == pfsa_pkg::SEL_UNLOCK && sfr.wdata == pfsa_pkg::UNLOCK_KEY2
                         && st.unlock == 2'd1) begin
                next_st.unlock = 2'd2;
            end else begin
                next_st.unlock = 2'd0;
            end
        end

        // Address and data pairs, frozen while an operation runs
        if (sfr.wr && st.state == pfsa_pkg::ST_IDLE) begin
            unique case (sfr.sel)
                pfsa_pkg::SEL_DATA_LO: next_st.data[7:0]  = sfr.wdata;
                pfsa_pkg::SEL_DATA_HI: next_st.data[13:8] = sfr.wdata[5:0];
                pfsa_pkg::SEL_ADDR_LO: next_st.addr[7:0]  = sfr.wdata;
                pfsa_pkg::SEL_ADDR_HI: next_st.addr[14:8] = sfr.wdata[6:0];
                default: ;
            endcase
        end

        // Control writes: mode bits only when idle, error flag cleared by zero
        if (ctrl_wr) begin
            next_st.write_enable = sfr.wdata[pfsa_pkg::CB_WRITE_ENABLE];
            if (!sfr.wdata[pfsa_pkg::CB_WRITE_ERROR_FLAG]) begin
                next_st.write_error_flag = 1'b0;
            end
            if (st.state == pfsa_pkg::ST_IDLE) begin
                next_st.free = sfr.wdata[pfsa_pkg::CB_FREE];
                next_st.lwlo = sfr.wdata[pfsa_pkg::CB_LWLO];
                next_st.config_space_select = sfr.wdata[pfsa_pkg::CB_CONFIG_SPACE_SELECT];
            end
        end

        // Operation sequencer
        unique case (st.state)
            pfsa_pkg::ST_IDLE: begin
                if (wr_start) begin
                    next_st.wr = 1'b1;
                    if (sfr.wdata[pfsa_pkg::CB_FREE]) begin
                        next_st.erase_go = 1'b1;
                        next_st.timer    = pfsa_pkg::TMR_W'(WRITE_CYC - 1);
                        next_st.state    = pfsa_pkg::ST_BUSY;
                    end else begin
                        next_st.state = pfsa_pkg::ST_LOAD;
                    end
                end else if (rd_start) begin
                    next_st.rd    = 1'b1;
                    next_st.state = pfsa_pkg::ST_FETCH;
                end
            end
            pfsa_pkg::ST_FETCH: begin
                next_st.data  = fl_rdata;
                next_st.rd    = 1'b0;
                next_st.state = pfsa_pkg::ST_IDLE;
            end
            pfsa_pkg::ST_LOAD: begin
                next_st.latch[st.addr[pfsa_pkg::ROW_W-1:0]] = st.data;
                if (st.lwlo) begin
                    next_st.wr    = 1'b0;
                    next_st.state = pfsa_pkg::ST_IDLE;
                end else begin
                    next_st.prog_go = 1'b1;
                    next_st.timer   = pfsa_pkg::TMR_W'(WRITE_CYC - 1);
                    next_st.state   = pfsa_pkg::ST_BUSY;
                end
            end
            pfsa_pkg::ST_BUSY: begin
                if (st.timer == '0) begin
                    next_st.wr    = 1'b0;
                    next_st.state = pfsa_pkg::ST_IDLE;
                    if (!st.free) begin
                        for (int i = 0; i < pfsa_pkg::ROW_WORDS; i++) begin
                            next_st.latch[i] = pfsa_pkg::LATCH_RST;
                        end
                    end
                end else begin
                    next_st.timer = st.timer - 1'b1;
                end
            end
        endcase

        // Reset: error flag caught if a write was cut short and por is low
        if (rst) begin
            next_st       = '0;
            next_st.state = pfsa_pkg::ST_IDLE;
            for (int i = 0; i < pfsa_pkg::ROW_WORDS; i++) begin
                next_st.latch[i] = pfsa_pkg::LATCH_RST;
            end
            next_st.write_error_flag = !por && (st.write_error_flag || st.state == pfsa_pkg::ST_LOAD
                            || st.state == pfsa_pkg::ST_BUSY);
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        st <= next_st;
    end

    //--------------------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------------------
    assign sfr_rdata        = st.rdata;
    assign ext_access_allow = !code_protect;
    assign fl_addr          = st.addr;
    assign fl_cfg           = st.config_space_select;
    assign fl_rd            = st.state == pfsa_pkg::ST_FETCH;
    assign fl_erase         = st.erase_go;
    assign fl_prog          = st.prog_go;
    assign fl_busy          = st.state == pfsa_pkg::ST_BUSY;
    assign fl_row_data      = st.latch;

    //--------------------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_rd_req;
        rd_start && !fl_busy;
    endsequence

    sequence s_fetch_done;
        fl_rd ##1 (!st.rd && st.data == $past(fl_rdata));
    endsequence

    a_rd_fetch: assert property (s_rd_req |=> s_fetch_done)
        else $error("read did not fetch in second cycle");

    a_unlock_zero: assert property (sfr.rd && sfr.sel == pfsa_pkg::SEL_UNLOCK |=> sfr_rdata == 8'h00)
        else $error("unlock register read nonzero");

    a_wr_refused: assert property (ctrl_wr && sfr.wdata[pfsa_pkg::CB_WR] && (!st.write_enable || !armed)
        && st.state == pfsa_pkg::ST_IDLE |=> !st.wr && st.state == pfsa_pkg::ST_IDLE)
        else $error("write started without enable or unlock");

    a_wp_block: assert property (wp_hit && st.state == pfsa_pkg::ST_IDLE |=> !fl_prog && !fl_erase && !st.wr)
        else $error("protected region written");

    a_write_error_flag_reset: assert property (@(posedge clk_sys) disable iff (por)
        rst && fl_busy |=> st.write_error_flag)
        else $error("interrupted write left no error flag");

    a_write_enable_reset: assert property (@(posedge clk_sys) disable iff (1'b0)
        rst |=> !st.write_enable && !st.wr && !st.rd)
        else $error("control bits not clear after reset");

    a_busy_end: assert property (fl_busy && st.timer == '0 |=> !fl_busy && !st.wr)
        else $error("timed write did not finish");

    a_busy_hold: assert property (fl_busy |-> st.wr)
        else $error("start bit dropped during write");

    a_latch_load: assert property (st.state == pfsa_pkg::ST_LOAD && st.lwlo
        |=> st.latch[$past(st.addr[4:0])] == $past(st.data) && !st.wr)
        else $error("latch not loaded from data pair");

    a_data_hold: assert property (st.state == pfsa_pkg::ST_IDLE && !(sfr.wr && (sfr.sel == pfsa_pkg::SEL_DATA_LO
        || sfr.sel == pfsa_pkg::SEL_DATA_HI)) |=> $stable(st.data))
        else $error("data pair changed without cause");

    a_prog_timed: assert property ($rose(fl_busy) |-> st.wr [*4])
        else $error("write not held by timer");
endmodule

// *** verification/pfsa_flash_model.sv ***
// Behavioural flash array seen by the self-access controller
module pfsa_flash_model (
    // Clock
    input  wire logic              clk_sys,
    // Array side
    input  wire logic [14:0]       fl_addr,
    input  wire logic              fl_rd,
    input  wire logic              fl_erase,
    input  wire logic              fl_prog,
    input  wire logic [31:0][13:0] fl_row_data,
    output logic      [13:0]       fl_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [13:0] mem [0:32767];
    logic [13:0] last = 14'h0000;
    // Preload a position-dependent pattern
    initial begin
        for (int i = 0; i < 32768; i++) begin
            mem[i] = 14'(i) ^ 14'h2a5a;
        end
    end
    // Outside a fetch the line shows the inverse of the last word
    assign fl_rdata = fl_rd ? mem[fl_addr] : ~last;
    // Whole-row erase; programming can only clear bits
    always @(posedge clk_sys) begin
        if (fl_rd) begin
            last <= mem[fl_addr];
        end
        for (int i = 0; i < 32; i++) begin
            if (fl_erase) begin
                mem[{fl_addr[14:5], 5'(i)}] <= 14'h3fff;
            end
            if (fl_prog) begin
                mem[{fl_addr[14:5], 5'(i)}] <= mem[{fl_addr[14:5], 5'(i)}] & fl_row_data[i];
            end
        end
    end
endmodule

// *** verification/pfsa_flash_ctrl_bench.sv ***
// Self-checking bench of the program flash self-access controller
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module pfsa_flash_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int W = 8;
    // Design-facing signals
    logic                clk_sys = 1'b0;
    logic                rst = 1'b1;
    logic                por = 1'b1;
    pfsa_pkg::pfsa_sfr_t sfr = '0;
    logic                code_protect = 1'b0;
    logic [1:0]          write_protect_region = 2'b11;
    logic [7:0]          sfr_rdata;
    logic                ext_access_allow, fl_cfg, fl_rd, fl_erase, fl_prog, fl_busy;
    logic [14:0]         fl_addr;
    logic [13:0]         fl_rdata;
    logic [31:0][13:0]   fl_row_data;
    int                  n_fail = 0;
    int                  checked = 0;
    int                  busy_cyc = 0;
    bit                  busy_last = 1'b0;
    pfsa_flash_ctrl #(.WRITE_CYC(W)) u_pfsa_flash_ctrl (
        .clk_sys(clk_sys), .rst(rst), .por(por), .sfr(sfr), .sfr_rdata(sfr_rdata),
        .code_protect(code_protect), .write_protect_region(write_protect_region),
        .ext_access_allow(ext_access_allow), .fl_addr(fl_addr), .fl_cfg(fl_cfg), .fl_rd(fl_rd),
        .fl_rdata(fl_rdata), .fl_erase(fl_erase), .fl_prog(fl_prog), .fl_busy(fl_busy),
        .fl_row_data(fl_row_data));
    pfsa_flash_model u_pfsa_flash_model (
        .clk_sys(clk_sys), .fl_addr(fl_addr), .fl_rd(fl_rd), .fl_erase(fl_erase),
        .fl_prog(fl_prog), .fl_row_data(fl_row_data), .fl_rdata(fl_rdata));
    //--------------------------------------------------------------------------
    // Clock, busy counter and helpers
    //--------------------------------------------------------------------------
    always #25ns clk_sys = ~clk_sys;
    // Length of the latest timed operation, sampled away from the rising edge
    always @(negedge clk_sys) begin
        if (fl_busy === 1'b1) begin
            busy_cyc <= busy_last ? busy_cyc + 1 : 1;
        end
        busy_last <= fl_busy === 1'b1;
    end
    function automatic logic [13:0] init_word(input logic [14:0] a);
        return a[13:0] ^ 14'h2a5a;
    endfunction
    function automatic bit wp_ok(input logic [1:0] r, input logic [14:0] a);
        return r == 2'b11 || (r == 2'b10 && a > 15'h01ff) || (r == 2'b01 && a > 15'h0fff);
    endfunction
    task automatic wr_reg(input pfsa_pkg::pfsa_sel_t s, input logic [7:0] d);
        sfr <= '{wr: 1'b1, rd: 1'b0, sel: s, wdata: d};
        @(posedge clk_sys);
    endtask
    task automatic idle(input int n);
        sfr <= '0;
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic rd_reg(input pfsa_pkg::pfsa_sel_t s, output logic [7:0] v);
        sfr <= '{wr: 1'b0, rd: 1'b1, sel: s, wdata: 8'h00};
        @(posedge clk_sys);
        sfr <= '0;
        @(posedge clk_sys);
        v = sfr_rdata;
    endtask
    task automatic rd_word(output logic [13:0] w);
        logic [7:0] l, h;
        rd_reg(pfsa_pkg::SEL_DATA_LO, l);
        rd_reg(pfsa_pkg::SEL_DATA_HI, h);
        w = {h[5:0], l};
    endtask
    task automatic set_addr(input logic [14:0] a);
        wr_reg(pfsa_pkg::SEL_ADDR_HI, {1'($urandom), a[14:8]});
        wr_reg(pfsa_pkg::SEL_ADDR_LO, a[7:0]);
    endtask
    // Read one word, leaving two idle cycles after the start
    task automatic flash_read(input logic [14:0] a, input logic [13:0] e);
        logic [13:0] w;
        set_addr(a);
        wr_reg(pfsa_pkg::SEL_CTRL, 8'h01);
        idle(2);
        rd_word(w);
        `CHK(w, e)
    endtask
    // Write enable, address, data, unlock pair, then a control write
    task automatic start(input logic [14:0] a, input logic [13:0] d, input logic [7:0] c);
        wr_reg(pfsa_pkg::SEL_CTRL, c & 8'h04); // Enable must stand before the start
        set_addr(a);
        wr_reg(pfsa_pkg::SEL_DATA_LO, d[7:0]);
        wr_reg(pfsa_pkg::SEL_DATA_HI, {2'b11, d[13:8]});
        wr_reg(pfsa_pkg::SEL_UNLOCK, pfsa_pkg::UNLOCK_KEY1);
        wr_reg(pfsa_pkg::SEL_UNLOCK, pfsa_pkg::UNLOCK_KEY2);
        wr_reg(pfsa_pkg::SEL_CTRL, c);
        idle(3);
    endtask
    task automatic wait_done;
        int n;
        logic [7:0] v;
        n = 0;
        while (fl_busy !== 1'b0 && n < 200) begin
            @(negedge clk_sys);
            n++;
        end
        @(posedge clk_sys);
        `CHK(busy_cyc, W)
        rd_reg(pfsa_pkg::SEL_CTRL, v);
        `CHK(v[1], 1'b0)
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        #(50ns * 20000);
        n_fail++;
        tally_and_finish;
    end
    //--------------------------------------------------------------------------
    // Main sequence
    //--------------------------------------------------------------------------
    initial begin
        logic [7:0]  v;
        logic [13:0] w, d;
        logic [14:0] a;
        v = 8'($urandom(32'h6b321ab0));
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd_reg(pfsa_pkg::SEL_CTRL, v);
        `CHK(v, 8'h00)
        wr_reg(pfsa_pkg::SEL_UNLOCK, 8'h55);
        rd_reg(pfsa_pkg::SEL_UNLOCK, v);
        `CHK(v, 8'h00)
        wr_reg(pfsa_pkg::SEL_CTRL, 8'h40);
        idle(2);
        `CHK(fl_cfg, 1'b1)
        $display("reset test done");
        for (int i = 0; i < 5; i++) begin
            a = (i == 0) ? 15'h7fff : 15'($urandom);
            flash_read(a, init_word(a));
            `CHK(fl_addr, a)
            `CHK(fl_cfg, 1'b0)
            rd_reg(pfsa_pkg::SEL_ADDR_HI, v);
            `CHK(v, {1'b0, a[14:8]})
            rd_reg(pfsa_pkg::SEL_CTRL, v);
            `CHK(v[0], 1'b0)
            rd_word(w);
            `CHK(w, init_word(a))
        end
        d = 14'($urandom);
        wr_reg(pfsa_pkg::SEL_DATA_LO, d[7:0]);
        wr_reg(pfsa_pkg::SEL_DATA_HI, {2'b11, d[13:8]});
        rd_word(w);
        `CHK(w, d)
        $display("read test done");
        a = {2'b01, 13'($urandom)};
        start(a, d, 8'h22);
        `CHK(fl_row_data[a[4:0]], 14'h3fff)
        rd_reg(pfsa_pkg::SEL_CTRL, v);
        `CHK(v[1], 1'b0)
        wr_reg(pfsa_pkg::SEL_CTRL, 8'h04);
        wr_reg(pfsa_pkg::SEL_CTRL, 8'h26);
        idle(3);
        `CHK(fl_row_data[a[4:0]], 14'h3fff)
        $display("refusal test done");
        start(a, 14'h0000, 8'h16);
        wait_done;
        flash_read(a, 14'h3fff);
        flash_read(a ^ 15'h001f, 14'h3fff);
        flash_read(a ^ 15'h0020, init_word(a ^ 15'h0020));
        start(a, d, 8'h26);
        `CHK(fl_row_data[a[4:0]], d)
        start(a ^ 15'h0001, ~d, 8'h06);
        wait_done;
        `CHK(fl_row_data[a[4:0]], 14'h3fff)
        flash_read(a, d);
        flash_read(a ^ 15'h0001, ~d);
        flash_read(a ^ 15'h0002, 14'h3fff);
        start(a ^ 15'h0002, d ^ 14'h1555, 8'h06);
        wait_done;
        flash_read(a ^ 15'h0002, d ^ 14'h1555);
        flash_read(a ^ 15'h0001, ~d);
        $display("erase and program test done");
        for (int r = 0; r < 4; r++) begin
            for (int k = 0; k < 3; k++) begin
                a = (k == 0) ? 15'h0100 : (k == 1) ? 15'h0800 : 15'h4000;
                write_protect_region <= 2'(r);
                code_protect <= r[0];
                start(a, 14'h0000, 8'h16);
                `CHK(fl_busy, wp_ok(2'(r), a))
                `CHK(ext_access_allow, ~r[0])
                if (fl_busy === 1'b1) wait_done;
            end
        end
        $display("protection test done");
        start(a, d, 8'h06);
        rst <= 1'b1;
        por <= 1'b0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd_reg(pfsa_pkg::SEL_CTRL, v);
        `CHK(v, 8'h08)
        wr_reg(pfsa_pkg::SEL_CTRL, 8'h00);
        rd_reg(pfsa_pkg::SEL_CTRL, v);
        `CHK(v, 8'h00)
        $display("interrupted write test done");
        tally_and_finish;
    end
endmodule
